// ===== rtl/adf_map.svh
// Register map, field positions, reset values and timing counts of the accelerometer filter path.
`ifndef ADF_MAP_SVH
`define ADF_MAP_SVH

// Register indices; byte address is four times the index
`define ADF_FILTER_IDX      8'h28
`define ADF_SELFTEST_IDX    8'h2E
`define ADF_RANGE_IDX       8'h2C
`define ADF_STATUS_IDX      8'h30

// Filter settings fields
`define ADF_ODR_LSB         0
`define ADF_ODR_MSB         3
`define ADF_HPF_LSB         4
`define ADF_HPF_MSB         6
`define ADF_ODR_MAX         4'hA
`define ADF_HPF_OFF         3'h0
`define ADF_HPF_SPARE       3'h7

// Self test fields
`define ADF_ST_EN_BIT       0
`define ADF_ST_FORCE_BIT    1

// Range field codes
`define ADF_RANGE_10G       2'h1

// Reset values
`define ADF_FILTER_RST      8'h00
`define ADF_SELFTEST_RST    8'h00
`define ADF_RANGE_RST       2'h1

// High-pass shift: first code, step per code
`define ADF_HPF_SHIFT_BASE  5'h06
`define ADF_HPF_SHIFT_STEP  5'h02

// Stage one decimation, as a power of two
`define ADF_STAGE1_LOG2     5'h02

// Overrange protection interval
`define ADF_CLK_HZ          20000000
`define ADF_PROTECT_US      500
`define ADF_PROTECT_CYC     ((`ADF_PROTECT_US * (`ADF_CLK_HZ / 1000000)))

`endif

// ===== rtl/adf_pkg.sv
// Types shared by the accelerometer filter path.
package adf_pkg;
    // Overrange protection states
    typedef enum logic [0:0] {
        ADF_RUN,
        ADF_PROTECT
    } adf_prot_state_t;

    // One converter sample
    typedef logic signed [19:0] adf_sample_t;
endpackage

// ===== rtl/adf_top.sv
// Decimation, high-pass, interpolation, overrange and self-test control with an APB register slave.
//
// Decided for this implementation: the APB slave port.
`include "adf_map.svh"

module adf_top #(
    parameter int unsigned PROTECT_CYCLES = `ADF_PROTECT_CYC  // Drive-off interval in clocks
) (
    input  wire logic                 mclk,
    input  wire logic                 arst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 adc_valid,
    input  wire adf_pkg::adf_sample_t adc_x,
    input  wire adf_pkg::adf_sample_t adc_y,
    input  wire adf_pkg::adf_sample_t adc_z,
    input  wire logic                 ovr_cmp_low,
    input  wire logic                 ovr_cmp_high,
    output adf_pkg::adf_sample_t      accel_x,
    output adf_pkg::adf_sample_t      accel_y,
    output adf_pkg::adf_sample_t      accel_z,
    output logic                      sample_valid,
    output adf_pkg::adf_sample_t      interp_x,
    output adf_pkg::adf_sample_t      interp_y,
    output adf_pkg::adf_sample_t      interp_z,
    output logic                      interp_valid,
    output logic                      drive_clk_off,
    output logic                      self_test_enable,
    output logic                      self_test_force
);

    // Arithmetic right shift of a wide value, cut to one sample
    function automatic adf_pkg::adf_sample_t adf_shr(input logic signed [35:0] v, input logic [4:0] sh);
        logic signed [35:0] t;
        t = v >>> sh;
        return t[19:0];
    endfunction

    // Byte address of a register index
    function automatic logic [7:0] adf_byte_addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

    // Reset release
    logic                rst_meta;            // First reset stage
    logic                rst_n;               // Synchronised reset

    // Registers
    logic [7:0]          filter_settings;     // Rate and high-pass corner
    logic [7:0]          self_test_control;   // Enable and force bits
    logic [1:0]          range_control;       // Full-scale range code

    // Decoded settings
    logic [3:0]          output_sample_rate;  // Effective rate code, clamped
    logic [2:0]          highpass_corner_select;
    logic                hpf_on;              // High-pass in the path
    logic [4:0]          hpf_shift;           // Pole shift for the corner

    // Comparator synchronisers
    logic [1:0]          cmp_s1;              // First stage, read only by cmp_s2
    logic [1:0]          cmp_s2;
    logic [1:0]          cmp_s3;
    logic [1:0]          cmp_ok;              // Accepted levels
    logic                ovr_trip;            // Threshold of current range

    // Overrange protection
    adf_pkg::adf_prot_state_t prot_state;
    logic [13:0]         prot_cnt;            // Remaining protect clocks

    // Filter state, one entry per axis
    adf_pkg::adf_sample_t adc_in [3];
    adf_pkg::adf_sample_t adc_sel [3];       // Zero while protecting
    logic signed [21:0]  s1_acc [3];          // Stage one running sum
    logic signed [21:0]  s1_sum [3];
    adf_pkg::adf_sample_t base [3];          // 4 kHz samples
    logic signed [29:0]  s2_acc [3];          // Stage two running sum
    logic signed [29:0]  s2_sum [3];
    adf_pkg::adf_sample_t dec [3];           // Decimated sample
    logic signed [35:0]  hp_lp [3];           // High-pass tracking pole
    logic signed [35:0]  next_hp_lp [3];
    adf_pkg::adf_sample_t hp_out [3];
    adf_pkg::adf_sample_t acc_q [3];         // Output samples
    adf_pkg::adf_sample_t itp [3];           // Interpolated output
    adf_pkg::adf_sample_t itp_step [3];      // Per-input-strobe step
    logic [1:0]          s1_cnt;              // Inputs in stage one
    logic [9:0]          s2_cnt;              // Base samples in stage two
    logic                s1_done;             // Stage one output ready
    logic                s2_done;             // Decimated sample ready
    logic [9:0]          s2_last;             // Last count of stage two

    // APB decode
    logic                apb_setup;
    logic                apb_write;
    logic                hit_filter;
    logic                hit_selftest;
    logic                hit_range;
    logic                hit_status;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Settings decode; spare rate codes clamp to the slowest rate
    always_comb begin
        highpass_corner_select = filter_settings[`ADF_HPF_MSB:`ADF_HPF_LSB];
        if (filter_settings[`ADF_ODR_MSB:`ADF_ODR_LSB] > `ADF_ODR_MAX) begin
            output_sample_rate = `ADF_ODR_MAX;
        end else begin
            output_sample_rate = filter_settings[`ADF_ODR_MSB:`ADF_ODR_LSB];
        end
        // Code 000 and the spare code both leave the filter out
        hpf_on    = (highpass_corner_select != `ADF_HPF_OFF) &&
                    (highpass_corner_select != `ADF_HPF_SPARE);
        // Each code moves the pole by a factor of four
        hpf_shift = `ADF_HPF_SHIFT_BASE +
                    5'(`ADF_HPF_SHIFT_STEP * (highpass_corner_select - 3'h1));
        s2_last   = 10'((11'h001 << output_sample_rate) - 11'h001);
    end

    // APB strobes
    always_comb begin
        apb_setup    = psel && !penable;
        apb_write    = psel && penable && pready && pwrite;
        hit_filter   = paddr == adf_byte_addr(`ADF_FILTER_IDX);
        hit_selftest = paddr == adf_byte_addr(`ADF_SELFTEST_IDX);
        hit_range    = paddr == adf_byte_addr(`ADF_RANGE_IDX);
        hit_status   = paddr == adf_byte_addr(`ADF_STATUS_IDX);
    end

    // Answer one cycle after setup; read data is captured in setup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (apb_setup) begin
            pready  <= 1'b1;
            pslverr <= !(hit_filter || hit_selftest || hit_range || hit_status);
            prdata  <= 32'h00000000;
            if (!pwrite) begin
                if (hit_filter) begin
                    prdata <= {24'h000000, filter_settings};
                end
                if (hit_selftest) begin
                    prdata <= {24'h000000, self_test_control};
                end
                if (hit_range) begin
                    prdata <= {30'h00000000, range_control};
                end
                if (hit_status) begin
                    prdata <= {29'h00000000, self_test_force, hpf_on, drive_clk_off};
                end
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Software registers; filter path powers up bypassed at 4 kHz
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            filter_settings   <= `ADF_FILTER_RST;
            self_test_control <= `ADF_SELFTEST_RST;
            range_control     <= `ADF_RANGE_RST;
        end else if (apb_write) begin
            if (hit_filter) begin
                filter_settings <= {1'b0, pwdata[6:0]};
            end
            if (hit_selftest) begin
                self_test_control <= {6'h00, pwdata[1:0]};
            end
            if (hit_range) begin
                range_control <= pwdata[1:0];
            end
        end
    end

    // Self-test drive; force only acts once the mode is enabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            self_test_enable <= 1'b0;
            self_test_force  <= 1'b0;
        end else begin
            self_test_enable <= self_test_control[`ADF_ST_EN_BIT];
            self_test_force  <= self_test_control[`ADF_ST_EN_BIT] &&
                                self_test_control[`ADF_ST_FORCE_BIT];
        end
    end

    // Comparator pins: three flops, accept when the last two agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_s1 <= 2'h0;
            cmp_s2 <= 2'h0;
            cmp_s3 <= 2'h0;
            cmp_ok <= 2'h0;
        end else begin
            cmp_s1 <= {ovr_cmp_high, ovr_cmp_low};
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
            for (int b = 0; b < 2; b++) begin
                if (cmp_s2[b] == cmp_s3[b]) begin
                    cmp_ok[b] <= cmp_s3[b];
                end
            end
        end
    end

    // Range codes 0 and 1 (10 g) trip on the lower comparator, wider ranges on the upper
    always_comb begin
        if (range_control == `ADF_RANGE_10G || range_control == 2'h0) begin
            ovr_trip = cmp_ok[0];
        end else begin
            ovr_trip = cmp_ok[1];
        end
    end

    // Protection holds the drive clocks off for a fixed interval, no retrigger
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prot_state    <= adf_pkg::ADF_RUN;
            prot_cnt      <= 14'h0000;
            drive_clk_off <= 1'b0;
        end else begin
            case (prot_state)
                adf_pkg::ADF_RUN: begin
                    if (ovr_trip) begin
                        prot_state    <= adf_pkg::ADF_PROTECT;
                        prot_cnt      <= 14'(PROTECT_CYCLES - 1);
                        drive_clk_off <= 1'b1;
                    end
                end
                adf_pkg::ADF_PROTECT: begin
                    if (prot_cnt == 14'h0000) begin
                        prot_state    <= adf_pkg::ADF_RUN;
                        drive_clk_off <= 1'b0;
                    end else begin
                        prot_cnt <= prot_cnt - 14'h0001;
                    end
                end
                default: begin
                    prot_state    <= adf_pkg::ADF_RUN;
                    drive_clk_off <= 1'b0;
                end
            endcase
        end
    end

    // Datapath arithmetic for all three axes
    always_comb begin
        adc_in[0] = adc_x;
        adc_in[1] = adc_y;
        adc_in[2] = adc_z;
        for (int i = 0; i < 3; i++) begin
            // With the sense drive off, feed zeros so the filters settle to zero
            adc_sel[i]    = drive_clk_off ? 20'sh00000 : adc_in[i];
            s1_sum[i]     = s1_acc[i] + {{2{adc_sel[i][19]}}, adc_sel[i]};
            base[i]       = adf_shr({{14{s1_sum[i][21]}}, s1_sum[i]}, `ADF_STAGE1_LOG2);
            s2_sum[i]     = s2_acc[i] + {{10{base[i][19]}}, base[i]};
            dec[i]        = adf_shr({{6{s2_sum[i][29]}}, s2_sum[i]}, 5'(output_sample_rate));
            // One-pole tracker; output is input minus the tracked low part
            // Signed on purpose: a negative error must shift arithmetically, not logically
            next_hp_lp[i] = hp_lp[i] + (($signed({dec[i], 16'h0000}) - hp_lp[i]) >>> hpf_shift);
            hp_out[i]     = hpf_on ? 20'(dec[i] - hp_lp[i][35:16]) : dec[i];
        end
        s1_done = adc_valid && (s1_cnt == 2'h3);
        s2_done = s1_done && (output_sample_rate == 4'h0 || s2_cnt == s2_last);
    end

    // Decimation counters and sums; rate changes take effect at once, mid-period
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_cnt <= 2'h0;
            s2_cnt <= 10'h000;
            for (int i = 0; i < 3; i++) begin
                s1_acc[i] <= 22'sh000000;
                s2_acc[i] <= 30'sh00000000;
            end
        end else if (adc_valid) begin
            s1_cnt <= s1_cnt + 2'h1;
            for (int i = 0; i < 3; i++) begin
                s1_acc[i] <= s1_done ? 22'sh000000 : s1_sum[i];
            end
            if (s1_done) begin
                // Stage two is skipped entirely at the 4 kHz rate
                s2_cnt <= s2_done ? 10'h000 : s2_cnt + 10'h001;
                for (int i = 0; i < 3; i++) begin
                    s2_acc[i] <= s2_done ? 30'sh00000000 : s2_sum[i];
                end
            end
        end
    end

    // High-pass pole and output samples, one strobe per output period
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sample_valid <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                hp_lp[i] <= 36'sh000000000;
                acc_q[i] <= 20'sh00000;
            end
        end else begin
            sample_valid <= s2_done;
            if (s2_done) begin
                for (int i = 0; i < 3; i++) begin
                    acc_q[i] <= hp_out[i];
                    // Bypassed pole follows the input so enabling starts clean
                    hp_lp[i] <= hpf_on ? next_hp_lp[i] : {dec[i], 16'h0000};
                end
            end
        end
    end

    // Interpolator: ramps toward each new sample over one output period
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            interp_valid <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                itp[i]      <= 20'sh00000;
                itp_step[i] <= 20'sh00000;
            end
        end else begin
            interp_valid <= adc_valid;
            for (int i = 0; i < 3; i++) begin
                if (sample_valid) begin
                    // Steps per period are four inputs times the rate divisor
                    itp_step[i] <= adf_shr({{16{acc_q[i][19]}}, acc_q[i]} - {{16{itp[i][19]}}, itp[i]},
                                           5'(output_sample_rate) + `ADF_STAGE1_LOG2);
                end
                if (adc_valid) begin
                    itp[i] <= itp[i] + itp_step[i];
                end
            end
        end
    end

    // Outputs straight from the sample and interpolator flops
    always_comb begin
        accel_x  = acc_q[0];
        accel_y  = acc_q[1];
        accel_z  = acc_q[2];
        interp_x = itp[0];
        interp_y = itp[1];
        interp_z = itp[2];
    end

endmodule // adf_top

// ===== testbench/adf_top_asserts.sv
// Port-level checks of the filter block: bus timing, self test, protection and sample strobes.
`include "adf_map.svh"

module adf_top_asserts #(
    parameter int unsigned PROTECT_CYCLES = 20  // Drive-off interval in clocks
) (
    input wire logic                 mclk,
    input wire logic                 arst_n,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 adc_valid,
    input wire logic                 ovr_cmp_low,
    input wire logic                 ovr_cmp_high,
    input wire adf_pkg::adf_sample_t accel_z,
    input wire logic                 sample_valid,
    input wire logic                 interp_valid,
    input wire logic                 drive_clk_off,
    input wire logic                 self_test_enable,
    input wire logic                 self_test_force
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_ST = 8'(4 * `ADF_SELFTEST_IDX);  // Self test byte address
    logic [15:0] hi_cnt;  // Clocks the drive has been off so far
    logic [1:0]  st_w;    // Last self test value written

    // Length of the current drive-off spell
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) hi_cnt <= '0;
        else if (drive_clk_off) hi_cnt <= hi_cnt + 16'h0001;
        else hi_cnt <= '0;
    end

    // Shadow of the self test register, so the mirror check needs no $past after a delay
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) st_w <= '0;
        else if (psel && penable && pready && pwrite && paddr == A_ST) st_w <= pwdata[1:0];
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_st_wr;
        psel && penable && pready && pwrite && paddr == A_ST;
    endsequence

    property p_ack;
        s_setup |=> pready;
    endproperty
    a_ack: assert property (p_ack) else $error("ready missing after setup");
    property p_ready_pulse;
        pready |-> psel && penable ##1 !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready outside access or too long");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_st_mirror;
        s_st_wr |-> ##[1:2] (self_test_enable == st_w[0] && self_test_force == &st_w);
    endproperty
    a_st_mirror: assert property (p_st_mirror) else $error("self test pins differ from register");
    property p_force;
        self_test_force |-> self_test_enable;
    endproperty
    a_force: assert property (p_force) else $error("stimulus without test mode");
    property p_prot_len;
        $fell(drive_clk_off) |-> hi_cnt == PROTECT_CYCLES;
    endproperty
    a_prot_len: assert property (p_prot_len) else $error("drive-off interval wrong length");
    property p_no_trip;
        (!ovr_cmp_low && !ovr_cmp_high) [*6] |=> !$rose(drive_clk_off);
    endproperty
    a_no_trip: assert property (p_no_trip) else $error("protection without overrange");
    property p_interp;
        adc_valid |=> interp_valid;
    endproperty
    a_interp: assert property (p_interp) else $error("interpolator strobe missing");
    property p_samp;
        sample_valid |-> $past(adc_valid);
    endproperty
    a_samp: assert property (p_samp) else $error("output strobe without input strobe");
    property p_hold;
        !sample_valid |-> $stable(accel_z);
    endproperty
    a_hold: assert property (p_hold) else $error("output changed between strobes");
endmodule // adf_top_asserts

// ===== testbench/adf_conv_model.sv
// Converter stand-in: one three-axis sample strobe every four clocks.
module adf_conv_model (
    input  wire logic                 mclk,
    input  wire logic                 run,
    input  wire adf_pkg::adf_sample_t level,
    output logic                      adc_valid,
    output adf_pkg::adf_sample_t      adc_x,
    output adf_pkg::adf_sample_t      adc_y,
    output adf_pkg::adf_sample_t      adc_z
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph;  // Strobe phase

    initial begin
        ph = '0;
        adc_valid = 1'b0;
        adc_x = '0;
        adc_y = '0;
        adc_z = '0;
    end

    // Full 20-bit samples on the strobe; scrambled otherwise so stale data never passes
    always @(posedge mclk) begin
        ph <= run ? ph + 2'h1 : 2'h0;
        adc_valid <= run && ph == 2'h3;
        if (run && ph == 2'h3) begin
            adc_x <= level;
            adc_y <= level >>> 1;
            adc_z <= -level;
        end else begin
            adc_x <= ~adc_x;
            adc_y <= ~adc_y;
            adc_z <= ~adc_z;
        end
    end
endmodule // adf_conv_model

// ===== testbench/adf_top_tb.sv
// Self-checking bench of the filter block: registers, decimation, high-pass codes, protection, self test.
`include "adf_map.svh"

module adf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROT = 20;  // Shortened drive-off interval
    localparam logic [7:0] A_FLT = 8'(4 * `ADF_FILTER_IDX);
    localparam logic [7:0] A_ST  = 8'(4 * `ADF_SELFTEST_IDX);
    localparam logic [7:0] A_RNG = 8'(4 * `ADF_RANGE_IDX);
    localparam logic [7:0] A_STS = 8'(4 * `ADF_STATUS_IDX);
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, adc_valid, run;
    logic ovr_cmp_low, ovr_cmp_high, sample_valid, interp_valid, drive_clk_off;
    logic self_test_enable, self_test_force;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    adf_pkg::adf_sample_t adc_x, adc_y, adc_z, accel_x, accel_y, accel_z, level;
    logic [32:0] aq[$];  // Expected {error, read data}
    logic [59:0] sq[$];  // Expected output samples
    int          pq[$];  // Expected drive-off lengths
    int error_cnt = 0;
    int num_checks = 0;
    int hc = 0;
    int i;
    int st_seq [5] = '{1, 3, 1, 2, 0};  // Self test writes: enable, force on/off, force alone, clear

    adf_top #(.PROTECT_CYCLES(PROT)) adf_top_i (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_valid(adc_valid), .adc_x(adc_x), .adc_y(adc_y), .adc_z(adc_z), .ovr_cmp_low(ovr_cmp_low),
        .ovr_cmp_high(ovr_cmp_high), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
        .sample_valid(sample_valid), .interp_x(), .interp_y(), .interp_z(), .interp_valid(interp_valid),
        .drive_clk_off(drive_clk_off), .self_test_enable(self_test_enable), .self_test_force(self_test_force));
    adf_conv_model adf_conv_model_i (.mclk(mclk), .run(run), .level(level), .adc_valid(adc_valid),
        .adc_x(adc_x), .adc_y(adc_y), .adc_z(adc_z));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One APB transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        aq.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Steady input for two flush periods, then expect the mean of the next period
    task automatic feed(input logic [3:0] rate, input logic [2:0] code);
        adf_pkg::adf_sample_t lv;
        int p;
        lv = $signed(20'($urandom)) >>> 1;
        p = 16 << rate;
        apb(1'b1, A_FLT, {25'h0, code, rate}, 33'h0);
        level <= lv;
        repeat (2 * p) @(posedge mclk);
        sq.push_back({lv, lv >>> 1, -lv});
        repeat (p + 16) @(posedge mclk);
    endtask

    // Overrange comparator pulse long enough to pass the synchroniser
    task automatic trip(input logic hi);
        if (hi) ovr_cmp_high <= 1'b1;
        else ovr_cmp_low <= 1'b1;
        repeat (6) @(posedge mclk);
        ovr_cmp_high <= 1'b0;
        ovr_cmp_low <= 1'b0;
        repeat (3 * PROT) @(posedge mclk);
    endtask

    // Monitor: takes the oldest note whenever a result shows at the ports
    always @(posedge mclk) begin
        if (pready === 1'b1) begin
            if (pwrite) chk(64'(pslverr), 64'(aq[0][32]));
            else chk(64'({pslverr, prdata}), 64'(aq[0]));
            void'(aq.pop_front());
        end
        if (sample_valid === 1'b1 && sq.size() > 0) chk(64'({accel_x, accel_y, accel_z}), 64'(sq.pop_front()));
        if (drive_clk_off === 1'b1) hc++;
        else if (hc != 0) begin
            chk(64'(hc), 64'(pq.size() > 0 ? pq.pop_front() : 0));
            hc = 0;
        end
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(50 * 20000);
        error_cnt++;
        test_done();
    end

    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, run, ovr_cmp_low, ovr_cmp_high} = '0;
        paddr = '0;
        pwdata = '0;
        level = '0;
        void'($urandom(32'hc72c));
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, A_FLT, 32'h0, 33'h0);
        apb(1'b0, A_ST, 32'h0, 33'h0);
        apb(1'b0, 8'h04, 32'h0, 33'h1_0000_0000);
        apb(1'b1, 8'h04, 32'h1, 33'h1_0000_0000);
        apb(1'b1, A_FLT, 32'h85, 33'h0);
        apb(1'b0, A_FLT, 32'h0, 33'h5);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, A_FLT, 32'(i << 4), 33'h0);
            apb(1'b0, A_STS, 32'h0, (i != 0 && i != 7) ? 33'h2 : 33'h0);
        end
        run <= 1'b1;
        for (i = 0; i < 5; i++) feed(4'(i == 4 ? 3 : i), i == 4 ? 3'h7 : 3'h0);
        pq.push_back(PROT);
        trip(1'b0);
        trip(1'b1);
        apb(1'b1, A_RNG, 32'h2, 33'h0);
        pq.push_back(PROT);
        trip(1'b1);
        trip(1'b0);
        for (i = 0; i < 5; i++) begin
            apb(1'b1, A_ST, 32'(st_seq[i]), 33'h0);
            apb(1'b0, A_ST, 32'h0, 33'(st_seq[i]));
            chk(64'({self_test_enable, self_test_force}), 64'({st_seq[i][0], &st_seq[i][1:0]}));
            apb(1'b0, A_STS, 32'h0, 33'({&st_seq[i][1:0], 2'b00}));
        end
        chk(64'(aq.size() + sq.size() + pq.size()), 64'h0);
        test_done();
    end
endmodule // adf_top_tb

bind adf_top adf_top_asserts #(.PROTECT_CYCLES(PROTECT_CYCLES)) adf_top_asserts_i (.mclk(mclk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid), .ovr_cmp_low(ovr_cmp_low),
    .ovr_cmp_high(ovr_cmp_high), .accel_z(accel_z), .sample_valid(sample_valid),
    .interp_valid(interp_valid), .drive_clk_off(drive_clk_off), .self_test_enable(self_test_enable),
    .self_test_force(self_test_force));
